// File: core/srg_pkg.sv
// constants for the speed-loop pi regulator
package srg_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_STATUS   = 8'h04;
  localparam logic [7:0] ADR_KP_HIGH  = 8'h08;
  localparam logic [7:0] ADR_TI_HIGH  = 8'h0c;
  localparam logic [7:0] ADR_KP_LOW   = 8'h10;
  localparam logic [7:0] ADR_TI_LOW   = 8'h14;
  localparam logic [7:0] ADR_DELAY    = 8'h18;
  localparam logic [7:0] ADR_SW_FREQ  = 8'h1c;
  localparam logic [7:0] ADR_I_LIMIT  = 8'h20;
  localparam logic [7:0] ADR_MFI_A    = 8'h24;
  localparam logic [7:0] ADR_MFI_B    = 8'h28;
  localparam logic [7:0] ADR_AO1_SEL  = 8'h2c;
  localparam logic [7:0] ADR_AO2_SEL  = 8'h30;
  localparam logic [7:0] ADR_AO_LEVEL = 8'h34;
  localparam logic [7:0] ADR_MAX_FREQ = 8'h38;
  localparam logic [7:0] ADR_OUT_MON  = 8'h3c;
  // ---------------------------------------------------------------
  // field positions, defaults and ranges
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_FLUX_BIT = 1;
  localparam logic [15:0] KP_DEF    = 16'h07d0;  // 20.00
  localparam logic [15:0] KP_MAX    = 16'h7530;  // 300.00
  localparam logic [15:0] TI_DEF    = 16'h01f4;  // 0.500 s
  localparam logic [15:0] TI_MAX    = 16'h2710;  // 10.000 s
  localparam logic [15:0] DELAY_DEF = 16'h0004;  // 0.004 s
  localparam logic [15:0] DELAY_MAX = 16'h01f4;  // 0.500 s
  localparam logic [15:0] FSW_DEF   = 16'h0000;  // 0.0 Hz
  localparam logic [15:0] FSW_MAX   = 16'h0fa0;  // 400.0 Hz
  localparam logic [15:0] ILIM_DEF  = 16'h0190;  // 400
  localparam logic [15:0] ILIM_MAX  = 16'h0190;
  localparam logic [15:0] MAXF_DEF  = 16'h0258;  // 60.0 Hz
  localparam logic [15:0] SEL_MAX   = 16'h00ff;
  localparam logic [7:0]  MFI_INTEG_RESET = 8'h0e;
  localparam logic [7:0]  MFI_GAIN_SELECT = 8'h77;
  localparam logic [7:0]  AO_SEL_ASR_IN   = 8'h15;
  localparam logic [7:0]  AO_SEL_SPEED    = 8'h05;
  localparam logic [7:0]  AO_LVL_BIPOLAR  = 8'h01;
  // ---------------------------------------------------------------
  // scaling and timing
  // ---------------------------------------------------------------
  localparam int KP_SCALE      = 100;    // gain lsb 0.01
  localparam int NORM_SCALE    = 10000;  // 0.01 % of max frequency
  localparam int ILIM_SCALE    = 100;    // limit in %, output 0.01 %
  localparam int FRAC_BITS     = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CTRL_PERIOD_NS = 10000;
  localparam int TICK_CYC      = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS  = 1000000 / CTRL_PERIOD_NS;
  localparam int NUM_MFI       = 6;
  localparam int DIV_W         = 40;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_NORM  = 8'h02,
    ST_SCHED = 8'h04,
    ST_RAMP  = 8'h08,
    ST_PROP  = 8'h10,
    ST_INTEG = 8'h20,
    ST_FILT  = 8'h40,
    ST_OUT   = 8'h80
  } srg_state_e;
endpackage

// File: core/srg_speed_regulator.sv
// speed-loop pi regulator with gain scheduling and wishbone registers
// Operation
// - high-speed gain 0.00..300.00, default 20.00, writable any time
// - high-speed integral time 0..10 s, default 0.5 s, writable any time
// - low-speed gain and integral time, same ranges and defaults
// - above switch frequency use high-speed gain and integral time
// - below switch frequency blend linearly, low-speed pair at zero
// - switch frequency zero means high-speed pair everywhere
// - integral-reset input forces proportional-only action while on
// - gain-select input picks low-speed gain while on, scheduled gain while off
// - gain-select input overrides frequency scheduling of the gain; integral time stays scheduled
// - gain-select change ramps gain over high-speed integral time
// - output delay filter 0..0.5 s, default 0.004, locked while running
// - integral term clamped to limit 0..400, default 400
// - flux vector mode normalises error to maximum output frequency
// - proportional term scales directly with gain setting
// - monitor code 21 gives regulator input, code 5 motor speed
// - level selection 1 makes monitor outputs bipolar
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module srg_speed_regulator (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [31:0]        i_wb_dat,
  input  wire logic [3:0]         i_wb_sel,
  output logic [31:0]             o_wb_dat,
  output logic                    o_wb_ack,
  input  wire logic signed [15:0] i_speed_ref,
  input  wire logic signed [15:0] i_motor_speed,
  input  wire logic [15:0]        i_out_freq,
  input  wire logic [5:0]         i_mfi,
  output logic signed [15:0]      o_torque_ref,
  output logic signed [15:0]      o_aout1,
  output logic signed [15:0]      o_aout2
);
  localparam int W = srg_pkg::DIV_W;
  localparam int FB = srg_pkg::FRAC_BITS;
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [15:0] mx);
    logic [15:0] m;
    m = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    return (m > mx) ? mx : m;
  endfunction
  function automatic logic mfi_any(input logic [47:0] sel, input logic [5:0] lv,
                                   input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < srg_pkg::NUM_MFI; k++) begin
      if (lv[k] && sel[8*k +: 8] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction
  function automatic logic signed [15:0] sat16(input logic signed [W-1:0] v);
    if (v > 40'sd32767) begin
      return 16'sh7fff;
    end else if (v < -40'sd32767) begin
      return -16'sh7fff;
    end
    return v[15:0];
  endfunction
  function automatic logic signed [15:0] ao_val(input logic [7:0] sel, input logic [7:0] lvl,
                                                input logic signed [15:0] a,
                                                input logic signed [15:0] b);
    logic signed [15:0] v;
    v = (sel == srg_pkg::AO_SEL_ASR_IN) ? a : (sel == srg_pkg::AO_SEL_SPEED) ? b : 16'sh0000;
    return (lvl != srg_pkg::AO_LVL_BIPOLAR && v < 0) ? 16'sh0000 : v;
  endfunction
  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic [1:0]  ctrl_r;
  logic [15:0] kp_hi_r, ti_hi_r, kp_lo_r, ti_lo_r, delay_r, fsw_r, ilim_r, maxf_r;
  logic [47:0] mfi_sel_r;
  logic [7:0]  ao1_sel_r, ao2_sel_r, ao_lvl_r;
  logic        wb_req, wb_wr, running;
  assign wb_req  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr   = wb_req && i_wb_we;
  assign running = ctrl_r[srg_pkg::CTRL_RUN_BIT];
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_r    <= 2'h0;
      kp_hi_r   <= srg_pkg::KP_DEF;
      ti_hi_r   <= srg_pkg::TI_DEF;
      kp_lo_r   <= srg_pkg::KP_DEF;
      ti_lo_r   <= srg_pkg::TI_DEF;
      delay_r   <= srg_pkg::DELAY_DEF;
      fsw_r     <= srg_pkg::FSW_DEF;
      ilim_r    <= srg_pkg::ILIM_DEF;
      maxf_r    <= srg_pkg::MAXF_DEF;
      mfi_sel_r <= 48'h0;
      ao1_sel_r <= srg_pkg::AO_SEL_ASR_IN;
      ao2_sel_r <= srg_pkg::AO_SEL_SPEED;
      ao_lvl_r  <= srg_pkg::AO_LVL_BIPOLAR;
    end else if (wb_wr) begin
      case (i_wb_adr)
        srg_pkg::ADR_CTRL:     ctrl_r  <= (i_wb_sel[0]) ? i_wb_dat[1:0] : ctrl_r;
        srg_pkg::ADR_KP_HIGH:  kp_hi_r <= wr16(kp_hi_r, i_wb_dat, i_wb_sel, srg_pkg::KP_MAX);
        srg_pkg::ADR_TI_HIGH:  ti_hi_r <= wr16(ti_hi_r, i_wb_dat, i_wb_sel, srg_pkg::TI_MAX);
        srg_pkg::ADR_KP_LOW:   kp_lo_r <= wr16(kp_lo_r, i_wb_dat, i_wb_sel, srg_pkg::KP_MAX);
        srg_pkg::ADR_TI_LOW:   ti_lo_r <= wr16(ti_lo_r, i_wb_dat, i_wb_sel, srg_pkg::TI_MAX);
        srg_pkg::ADR_DELAY: begin
          if (!running) begin
            delay_r <= wr16(delay_r, i_wb_dat, i_wb_sel, srg_pkg::DELAY_MAX);
          end
        end
        srg_pkg::ADR_SW_FREQ: begin
          if (!running) begin
            fsw_r <= wr16(fsw_r, i_wb_dat, i_wb_sel, srg_pkg::FSW_MAX);
          end
        end
        srg_pkg::ADR_I_LIMIT:  ilim_r  <= wr16(ilim_r, i_wb_dat, i_wb_sel, srg_pkg::ILIM_MAX);
        srg_pkg::ADR_MAX_FREQ: maxf_r  <= wr16(maxf_r, i_wb_dat, i_wb_sel, 16'hffff);
        srg_pkg::ADR_MFI_A: begin
          for (int k = 0; k < 4; k++) begin
            if (i_wb_sel[k]) mfi_sel_r[8*k +: 8] <= i_wb_dat[8*k +: 8];
          end
        end
        srg_pkg::ADR_MFI_B: begin
          for (int k = 0; k < 2; k++) begin
            if (i_wb_sel[k]) mfi_sel_r[32+8*k +: 8] <= i_wb_dat[8*k +: 8];
          end
        end
        srg_pkg::ADR_AO1_SEL:  ao1_sel_r <= (i_wb_sel[0]) ? i_wb_dat[7:0] : ao1_sel_r;
        srg_pkg::ADR_AO2_SEL:  ao2_sel_r <= (i_wb_sel[0]) ? i_wb_dat[7:0] : ao2_sel_r;
        srg_pkg::ADR_AO_LEVEL: ao_lvl_r  <= (i_wb_sel[0]) ? i_wb_dat[7:0] : ao_lvl_r;
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // input pins: three stages, change taken when stages two and three agree
  // ---------------------------------------------------------------
  logic [5:0] mfi_s1_r, mfi_s2_r, mfi_s3_r, mfi_r;
  logic       irst, gsel;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mfi_s1_r <= 6'h00;
      mfi_s2_r <= 6'h00;
      mfi_s3_r <= 6'h00;
      mfi_r    <= 6'h00;
    end else begin
      mfi_s1_r <= i_mfi;
      mfi_s2_r <= mfi_s1_r;
      mfi_s3_r <= mfi_s2_r;
      mfi_r    <= (mfi_s2_r & ~(mfi_s2_r ^ mfi_s3_r)) | (mfi_r & (mfi_s2_r ^ mfi_s3_r));
    end
  end
  assign irst = mfi_any(mfi_sel_r, mfi_r, srg_pkg::MFI_INTEG_RESET);
  assign gsel = mfi_any(mfi_sel_r, mfi_r, srg_pkg::MFI_GAIN_SELECT);
  // ---------------------------------------------------------------
  // control period enable
  // ---------------------------------------------------------------
  logic [9:0] tick_cnt_r;
  logic       tick_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick_cnt_r == 10'(srg_pkg::TICK_CYC - 1)) begin
      tick_cnt_r <= 10'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 10'h001;
    end
    tick_r <= !i_rst && tick_cnt_r == 10'(srg_pkg::TICK_CYC - 1);
  end
  // ---------------------------------------------------------------
  // shared restoring divider, signed numerator, positive divisor
  // ---------------------------------------------------------------
  srg_pkg::srg_state_e st_r;
  logic                ph_r, need_div, dv_start, dv_neg_r, dv_done_r, dv_busy_r;
  logic signed [W-1:0] num, dv_res;
  logic [23:0]         den, dv_den_r;
  logic [W-1:0]        dv_q_r;
  logic [24:0]         dv_rem_r, dv_rs;
  logic [5:0]          dv_cnt_r;
  assign dv_start = need_div && !ph_r && st_r != srg_pkg::ST_IDLE;
  assign dv_rs    = {dv_rem_r[23:0], dv_q_r[W-1]};
  assign dv_res   = dv_neg_r ? -$signed(dv_q_r) : $signed(dv_q_r);
  always_ff @(posedge i_clk_sys) begin
    dv_done_r <= 1'b0;
    if (i_rst) begin
      dv_busy_r <= 1'b0;
      dv_q_r    <= '0;
      dv_rem_r  <= '0;
      dv_den_r  <= '0;
      dv_cnt_r  <= '0;
      dv_neg_r  <= 1'b0;
    end else if (dv_start) begin
      dv_busy_r <= 1'b1;
      dv_neg_r  <= num[W-1];
      dv_q_r    <= num[W-1] ? W'(-num) : num;
      dv_rem_r  <= '0;
      dv_den_r  <= den;
      dv_cnt_r  <= 6'(W);
    end else if (dv_busy_r) begin
      if (dv_rs >= {1'b0, dv_den_r}) begin
        dv_rem_r <= dv_rs - {1'b0, dv_den_r};
        dv_q_r   <= {dv_q_r[W-2:0], 1'b1};
      end else begin
        dv_rem_r <= dv_rs;
        dv_q_r   <= {dv_q_r[W-2:0], 1'b0};
      end
      dv_cnt_r <= dv_cnt_r - 6'h01;
      if (dv_cnt_r == 6'h01) begin
        dv_busy_r <= 1'b0;
        dv_done_r <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // regulator sequence, one pass per control period
  // ---------------------------------------------------------------
  logic signed [16:0]  err_r;
  logic signed [23:0]  e_r;
  logic [15:0]         kps_r, tis_r, kp_act_r, kp_from_r;
  logic                gs_prev_r, ramp_on_r, high_r, clamp_r;
  logic [23:0]         ramp_cnt_r, ramp_len_r;
  logic signed [W-1:0] p_r, acc_r, y_r, ilim_w, x_w, acc_nxt;
  logic signed [15:0]  ref_r, spd_r;
  logic [15:0]         kp_tgt;
  assign ilim_w  = W'(ilim_r) * srg_pkg::ILIM_SCALE <<< FB;
  assign x_w     = p_r + (acc_r >>> FB);
  assign acc_nxt = acc_r + dv_res;
  assign kp_tgt  = gsel ? kp_lo_r : kps_r;
  always_comb begin
    need_div = 1'b0;
    num      = '0;
    den      = 24'h000001;
    case (st_r)
      srg_pkg::ST_NORM: begin
        need_div = ctrl_r[srg_pkg::CTRL_FLUX_BIT] && maxf_r != 16'h0000;
        num      = W'(err_r) * srg_pkg::NORM_SCALE;
        den      = 24'(maxf_r);
      end
      srg_pkg::ST_SCHED: begin
        need_div = fsw_r != 16'h0000 && i_out_freq < fsw_r;
        num      = W'(i_out_freq) <<< FB;
        den      = 24'(fsw_r);
      end
      srg_pkg::ST_RAMP: begin
        need_div = ramp_on_r && gs_prev_r == gsel;
        num      = (W'(kp_tgt) - W'(kp_from_r)) * $signed({1'b0, ramp_cnt_r});
        den      = ramp_len_r;
      end
      srg_pkg::ST_PROP: begin
        need_div = 1'b1;
        num      = W'(kp_act_r) * W'(e_r);
        den      = 24'(srg_pkg::KP_SCALE);
      end
      srg_pkg::ST_INTEG: begin
        need_div = !irst && tis_r != 16'h0000;
        num      = W'(e_r) <<< FB;
        den      = 24'(tis_r) * 24'(srg_pkg::TICKS_PER_MS);
      end
      srg_pkg::ST_FILT: begin
        need_div = delay_r != 16'h0000;
        num      = (x_w <<< FB) - y_r;
        den      = 24'(delay_r) * 24'(srg_pkg::TICKS_PER_MS);
      end
      default: ;
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= srg_pkg::ST_IDLE;
      ph_r <= 1'b0;
      {err_r, e_r, ref_r, spd_r} <= '0;
      kps_r      <= srg_pkg::KP_DEF;
      tis_r      <= srg_pkg::TI_DEF;
      kp_act_r   <= srg_pkg::KP_DEF;
      kp_from_r  <= srg_pkg::KP_DEF;
      {gs_prev_r, ramp_on_r, high_r, clamp_r} <= 4'h0;
      ramp_cnt_r <= '0;
      ramp_len_r <= '0;
      {p_r, acc_r, y_r} <= '0;
    end else if (st_r == srg_pkg::ST_IDLE) begin
      if (tick_r) begin
        ref_r <= i_speed_ref;
        spd_r <= i_motor_speed;
        err_r <= 17'(i_speed_ref) - 17'(i_motor_speed);
        st_r  <= srg_pkg::ST_NORM;
      end
    end else if (dv_start) begin
      ph_r <= 1'b1;
    end else if (ph_r ? dv_done_r : 1'b1) begin
      ph_r <= 1'b0;
      case (st_r)
        srg_pkg::ST_NORM: begin
          e_r  <= need_div ? 24'(dv_res) : 24'(err_r);
          st_r <= srg_pkg::ST_SCHED;
        end
        srg_pkg::ST_SCHED: begin
          high_r <= !need_div;
          kps_r  <= !need_div ? kp_hi_r : 16'(W'(kp_lo_r) +
                    ((W'(kp_hi_r) - W'(kp_lo_r)) * dv_res >>> FB));
          tis_r  <= !need_div ? ti_hi_r : 16'(W'(ti_lo_r) +
                    ((W'(ti_hi_r) - W'(ti_lo_r)) * dv_res >>> FB));
          st_r   <= srg_pkg::ST_RAMP;
        end
        srg_pkg::ST_RAMP: begin
          gs_prev_r <= gsel;
          if (gs_prev_r != gsel) begin
            kp_from_r  <= kp_act_r;
            ramp_cnt_r <= 24'h000001;
            ramp_len_r <= 24'(ti_hi_r) * 24'(srg_pkg::TICKS_PER_MS);
            ramp_on_r  <= ti_hi_r != 16'h0000;
            if (ti_hi_r == 16'h0000) kp_act_r <= kp_tgt;
          end else if (ramp_on_r) begin
            kp_act_r   <= 16'(W'(kp_from_r) + dv_res);
            ramp_cnt_r <= ramp_cnt_r + 24'h000001;
            ramp_on_r  <= ramp_cnt_r < ramp_len_r;
          end else begin
            kp_act_r <= kp_tgt;
          end
          st_r <= srg_pkg::ST_PROP;
        end
        srg_pkg::ST_PROP: begin
          p_r  <= dv_res;
          st_r <= srg_pkg::ST_INTEG;
        end
        srg_pkg::ST_INTEG: begin
          clamp_r <= 1'b0;
          if (irst) begin
            acc_r <= '0;
          end else if (need_div) begin
            if (acc_nxt > ilim_w || acc_nxt < -ilim_w) begin
              acc_r   <= (acc_nxt > ilim_w) ? ilim_w : -ilim_w;
              clamp_r <= 1'b1;
            end else begin
              acc_r <= acc_nxt;
            end
          end
          st_r <= srg_pkg::ST_FILT;
        end
        srg_pkg::ST_FILT: begin
          y_r  <= need_div ? y_r + dv_res : x_w <<< FB;
          st_r <= srg_pkg::ST_OUT;
        end
        default: st_r <= srg_pkg::ST_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_torque_ref <= 16'sh0000;
      o_aout1      <= 16'sh0000;
      o_aout2      <= 16'sh0000;
    end else if (st_r == srg_pkg::ST_OUT) begin
      o_torque_ref <= sat16(y_r >>> FB);
      o_aout1      <= ao_val(ao1_sel_r, ao_lvl_r, ref_r, spd_r);
      o_aout2      <= ao_val(ao2_sel_r, ao_lvl_r, ref_r, spd_r);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      case (i_wb_adr)
        srg_pkg::ADR_CTRL:     o_wb_dat <= {30'h0, ctrl_r};
        srg_pkg::ADR_STATUS:   o_wb_dat <= {27'h0, clamp_r, high_r, ramp_on_r, gsel, irst};
        srg_pkg::ADR_KP_HIGH:  o_wb_dat <= {16'h0, kp_hi_r};
        srg_pkg::ADR_TI_HIGH:  o_wb_dat <= {16'h0, ti_hi_r};
        srg_pkg::ADR_KP_LOW:   o_wb_dat <= {16'h0, kp_lo_r};
        srg_pkg::ADR_TI_LOW:   o_wb_dat <= {16'h0, ti_lo_r};
        srg_pkg::ADR_DELAY:    o_wb_dat <= {16'h0, delay_r};
        srg_pkg::ADR_SW_FREQ:  o_wb_dat <= {16'h0, fsw_r};
        srg_pkg::ADR_I_LIMIT:  o_wb_dat <= {16'h0, ilim_r};
        srg_pkg::ADR_MFI_A:    o_wb_dat <= mfi_sel_r[31:0];
        srg_pkg::ADR_MFI_B:    o_wb_dat <= {16'h0, mfi_sel_r[47:32]};
        srg_pkg::ADR_AO1_SEL:  o_wb_dat <= {24'h0, ao1_sel_r};
        srg_pkg::ADR_AO2_SEL:  o_wb_dat <= {24'h0, ao2_sel_r};
        srg_pkg::ADR_AO_LEVEL: o_wb_dat <= {24'h0, ao_lvl_r};
        srg_pkg::ADR_MAX_FREQ: o_wb_dat <= {16'h0, maxf_r};
        srg_pkg::ADR_OUT_MON:  o_wb_dat <= {{16{o_torque_ref[15]}}, o_torque_ref};
        default:               o_wb_dat <= 32'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/srg_speed_regulator_assertions.sv
// checker for the speed-loop regulator ports
`timescale 1ns/1ps
`default_nettype none
module srg_speed_regulator_assertions (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [31:0]        o_wb_dat,
  input  wire logic               o_wb_ack,
  input  wire logic signed [15:0] o_torque_ref
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic       rd_r;
  logic [7:0] adr_r;
  logic [10:0] gap_r;
  always_ff @(posedge i_clk_sys) begin
    rd_r  <= !i_rst && i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
    adr_r <= i_wb_adr;
  end
  // cycles since the regulator output last moved
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || $changed(o_torque_ref)) gap_r <= 11'h000;
    else if (gap_r != 11'h7ff) gap_r <= gap_r + 11'h001;
  end
  a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_kp_range: assert property (o_wb_ack && rd_r && (adr_r == srg_pkg::ADR_KP_HIGH ||
    adr_r == srg_pkg::ADR_KP_LOW) |-> o_wb_dat[15:0] <= srg_pkg::KP_MAX)
    else $error("gain above range");
  a_ti_range: assert property (o_wb_ack && rd_r && (adr_r == srg_pkg::ADR_TI_HIGH ||
    adr_r == srg_pkg::ADR_TI_LOW) |-> o_wb_dat[15:0] <= srg_pkg::TI_MAX)
    else $error("integral time above range");
  a_delay_range: assert property (o_wb_ack && rd_r && adr_r == srg_pkg::ADR_DELAY |->
    o_wb_dat[15:0] <= srg_pkg::DELAY_MAX) else $error("delay above range");
  a_fsw_range: assert property (o_wb_ack && rd_r && adr_r == srg_pkg::ADR_SW_FREQ |->
    o_wb_dat[15:0] <= srg_pkg::FSW_MAX) else $error("switch frequency above range");
  a_ilim_range: assert property (o_wb_ack && rd_r && adr_r == srg_pkg::ADR_I_LIMIT |->
    o_wb_dat[15:0] <= srg_pkg::ILIM_MAX) else $error("integral limit above range");
  a_update_gap: assert property ($changed(o_torque_ref) |-> gap_r >= 11'd700)
    else $error("output updated twice in one period");
endmodule
bind srg_speed_regulator srg_speed_regulator_assertions u_chk (.i_clk_sys, .i_rst, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_torque_ref);
`default_nettype wire

// File: verif/srg_motor_model.sv
// motor and speed feedback model
`timescale 1ns/1ps
`default_nettype none
module srg_motor_model (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic signed [15:0] i_torque,
  input  wire logic               i_hold,
  input  wire logic signed [15:0] i_hold_val,
  output logic signed [15:0]      o_speed
);
  logic [9:0] div_r;
  always_ff @(posedge i_clk_sys) begin
    div_r <= (i_rst || div_r == 10'h3e7) ? 10'h000 : div_r + 10'h001;
  end
  // shaft speed follows torque once a period; hold pins it for exact checks
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_speed <= 16'sh0000;
    else if (i_hold) o_speed <= i_hold_val;
    else if (div_r == 10'h3e7) o_speed <= o_speed + (i_torque >>> 9);
  end
endmodule
`default_nettype wire

// File: verif/srg_speed_regulator_tb.sv
// self-checking bench for the speed-loop regulator
`timescale 1ns/1ps
`default_nettype none
module srg_speed_regulator_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic hold = 1'b0;
  logic ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [5:0] mfi = 6'h00;
  logic [15:0] ofreq = 16'h0000;
  logic signed [15:0] sref = 16'sh0000;
  logic signed [15:0] hval = 16'sh0000;
  logic signed [15:0] mspd, trq, ao1, ao2;
  int errors = 0;
  int checks = 0;
  always #5 clk = ~clk;
  srg_speed_regulator DUT (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_speed_ref(sref), .i_motor_speed(mspd), .i_out_freq(ofreq),
    .i_mfi(mfi), .o_torque_ref(trq), .o_aout1(ao1), .o_aout2(ao2));
  srg_motor_model u_motor (.i_clk_sys(clk), .i_rst(rst), .i_torque(trq), .i_hold(hold),
    .i_hold_val(hval), .o_speed(mspd));
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      errors++;
      end_of_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, {16'h0000, exp});
  endtask
  task automatic sat(input logic [7:0] a, input logic [15:0] mx);
    bus(1'b1, a, 32'h0000ffff);
    rd_chk(a, mx);
  endtask
  task automatic periods(input int n);
    repeat (n * 1000) @(posedge clk);
  endtask
  task automatic t_regs;
    logic [15:0] d [12];
    d = '{srg_pkg::KP_DEF, srg_pkg::TI_DEF, srg_pkg::KP_DEF, srg_pkg::TI_DEF,
      srg_pkg::DELAY_DEF, srg_pkg::FSW_DEF, srg_pkg::ILIM_DEF, 16'h0000, 16'h0000,
      {8'h00, srg_pkg::AO_SEL_ASR_IN}, {8'h00, srg_pkg::AO_SEL_SPEED},
      {8'h00, srg_pkg::AO_LVL_BIPOLAR}};
    for (int i = 0; i < 12; i++) begin
      rd_chk(8'h08 + 8'(4 * i), d[i]);
    end
    rd_chk(8'h40, 16'h0000);
    sat(srg_pkg::ADR_KP_HIGH, srg_pkg::KP_MAX);
    sat(srg_pkg::ADR_TI_LOW, srg_pkg::TI_MAX);
    sat(srg_pkg::ADR_DELAY, srg_pkg::DELAY_MAX);
    sat(srg_pkg::ADR_SW_FREQ, srg_pkg::FSW_MAX);
    sat(srg_pkg::ADR_I_LIMIT, srg_pkg::ILIM_MAX);
    bus(1'b1, srg_pkg::ADR_CTRL, 32'h1);
    bus(1'b1, srg_pkg::ADR_DELAY, 32'h0);
    rd_chk(srg_pkg::ADR_DELAY, srg_pkg::DELAY_MAX);
    bus(1'b1, srg_pkg::ADR_KP_HIGH, 32'h04d2);
    rd_chk(srg_pkg::ADR_KP_HIGH, 16'h04d2);
    bus(1'b1, srg_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, srg_pkg::ADR_DELAY, 32'h0);
  endtask
  task automatic t_sched;
    logic [15:0] fsw [4] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h0000};
    logic [15:0] frq [4] = '{16'h0000, 16'h01f4, 16'h04b0, 16'h0000};
    logic [15:0] exp [4] = '{16'h01f4, 16'h02ee, 16'h03e8, 16'h03e8};
    bus(1'b1, srg_pkg::ADR_KP_HIGH, 32'h07d0);
    bus(1'b1, srg_pkg::ADR_KP_LOW, 32'h03e8);
    bus(1'b1, srg_pkg::ADR_MFI_A, 32'h0e);
    hold <= 1'b1;
    hval <= -16'sd20;
    sref <= 16'sd30;
    mfi <= 6'h01;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, srg_pkg::ADR_SW_FREQ, {16'h0000, fsw[i]});
      ofreq <= frq[i];
      periods(4);
      chk({16'h0000, trq}, {16'h0000, exp[i]});
    end
    chk({16'h0000, ao1}, 32'h0000001e);
    chk({16'h0000, ao2}, 32'h0000ffec);
    bus(1'b1, srg_pkg::ADR_AO_LEVEL, 32'h0);
    periods(2);
    chk({16'h0000, ao2}, 32'h00000000);
  endtask
  task automatic t_integ;
    bus(1'b1, srg_pkg::ADR_KP_HIGH, 32'h0);
    bus(1'b1, srg_pkg::ADR_TI_HIGH, 32'h1);
    bus(1'b1, srg_pkg::ADR_I_LIMIT, 32'h1);
    hval <= 16'sd0;
    sref <= 16'sd30000;
    mfi <= 6'h00;
    periods(4);
    chk({16'h0000, trq}, 32'h00000064);
    sref <= -16'sd30000;
    periods(4);
    chk({16'h0000, trq}, 32'h0000ff9c);
    mfi <= 6'h01;
    periods(3);
    mfi <= 6'h00;
    sref <= 16'sd0;
    periods(4);
    chk({16'h0000, trq}, 32'h00000000);
    bus(1'b1, srg_pkg::ADR_CTRL, 32'h2);
    bus(1'b1, srg_pkg::ADR_KP_HIGH, 32'h64);
    mfi <= 6'h01;
    sref <= 16'sd6;
    periods(4);
    chk({16'h0000, trq}, 32'h00000064);
  endtask
  task automatic t_gsel;
    bus(1'b1, srg_pkg::ADR_TI_HIGH, 32'h0);
    bus(1'b1, srg_pkg::ADR_MFI_A, 32'h770e);
    mfi <= 6'h03;
    periods(3);
    chk({16'h0000, trq}, 32'h000003e8);
    rd_chk(srg_pkg::ADR_STATUS, 16'h000b);
    bus(1'b1, srg_pkg::ADR_TI_HIGH, 32'h1);
    mfi <= 6'h01;
    periods(2);
    rd_chk(srg_pkg::ADR_STATUS, 16'h000d);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sched();
    t_integ();
    t_gsel();
    end_of_test();
  end
endmodule
`default_nettype wire
